// [design/uocs_params.svh]
// Operation
// - upper byte of every register reads zero; only low byte has fields
// - plug type flag: 1 no plug or type B, 0 type A inserted
// - line stable flag set only if line state unchanged for previous 1 ms
// - session valid flag follows VBUS above session valid threshold
// - session end flag is 1 while VBUS below session end threshold
// - VBUS valid flag is 1 while VBUS exceeds VBUS valid threshold
// - OTG enable 0: D+ pull-up and pull-downs from host and module enable, D- pull-up off; 1: software bits
// - activity pending set by hardware, meaningful only with suspend guard
// - suspend enable gates USB clock, low-power transceiver; hardware clears
// - after each transfer load last endpoint number field
// - last direction flag: 1 transmit, 0 receive
// - ping-pong indicator shows odd bank 1 or even bank 0
// - live flag shows single-ended zero on the lines
// - packet disable halts engine; set on SETUP token, software clears
// - resume bit drives resume signalling while set
// - ping-pong reset forces all bank pointers to even
`ifndef UOCS_PARAMS_SVH
`define UOCS_PARAMS_SVH
`define UOCS_ADDR_W 3
`define UOCS_OFS_OTGSTAT 3'h0
`define UOCS_OFS_OTGCON 3'h1
`define UOCS_OFS_PWRC 3'h2
`define UOCS_OFS_STAT 3'h3
`define UOCS_OFS_CON 3'h4
`define UOCS_BIT_ID 7
`define UOCS_BIT_LSTABLE 5
`define UOCS_BIT_SESSION_VALID_FLAG 3
`define UOCS_BIT_SESSION_END_FLAG 2
`define UOCS_BIT_VBUS_VALID_FLAG 0
`define UOCS_BIT_DPPU 7
`define UOCS_BIT_DMPU 6
`define UOCS_BIT_DPPD 5
`define UOCS_BIT_DMPD 4
`define UOCS_BIT_VBON 3
`define UOCS_BIT_OTG_FEATURE_ENABLE 2
`define UOCS_BIT_VBCHG 1
`define UOCS_BIT_VBDIS 0
`define UOCS_BIT_ACTPND 7
`define UOCS_BIT_GUARD 4
`define UOCS_BIT_SUSP 1
`define UOCS_BIT_PWR 0
`define UOCS_BIT_DIR 3
`define UOCS_BIT_PINGPONG_BANK_INDICATOR 2
`define UOCS_BIT_SE0 6
`define UOCS_BIT_PACKET_DISABLE 5
`define UOCS_BIT_HOST_MODE_ENABLE 3
`define UOCS_BIT_RESUME 2
`define UOCS_BIT_PINGPONG_RESET 1
`define UOCS_BIT_MODULE_ENABLE 0
`define UOCS_OTGCON_WMASK 8'hFF
`define UOCS_PWRC_WMASK 8'h13
`define UOCS_CON_WMASK 8'h2F
`define UOCS_ZERO_BYTE 8'h00
`define UOCS_STABLE_NS 1000000
`define UOCS_CLK_NS 10
`define UOCS_STABLE_CYC (`UOCS_STABLE_NS / `UOCS_CLK_NS)
`endif

// [design/uocs_pkg.sv]
package uocs_pkg;
  typedef logic [7:0] uocs_byte_t;
  typedef logic [15:0] uocs_word_t;
  typedef enum logic [1:0] {
    UOCS_LINE_SE0,
    UOCS_LINE_J,
    UOCS_LINE_K
  } uocs_line_t;
endpackage

// [design/uocs_regs.sv]
`timescale 1ns/1ps
`include "uocs_params.svh"
module uocs_regs
  import uocs_pkg::*;
#(
  parameter int STABLE_CYCLES = `UOCS_STABLE_CYC
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [`UOCS_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic id_pin,
  input wire logic line_se0,
  input wire logic line_j,
  input wire logic vbus_sess_vld,
  input wire logic vbus_sess_end,
  input wire logic vbus_vld,
  input wire logic xfer_done,
  input wire logic [3:0] xfer_endpoint,
  input wire logic xfer_tx,
  input wire logic xfer_odd,
  input wire logic setup_token,
  input wire logic activity_busy,
  input wire logic resume_detect,
  output logic dplus_pullup,
  output logic dminus_pullup,
  output logic dplus_pulldown,
  output logic dminus_pulldown,
  output logic vbus_power_on,
  output logic vbus_charge_select,
  output logic vbus_discharge_enable,
  output logic usb_clk_gate_n,
  output logic xcvr_low_power,
  output logic module_active,
  output logic engine_halt,
  output logic resume_drive,
  output logic pingpong_force_even
);
  localparam int CW = $clog2(STABLE_CYCLES + 1);
  localparam logic [CW-1:0] STABLE_MAX = CW'(STABLE_CYCLES);

  // three-stage synchronisers for the pin inputs
  logic [5:0] s1, s2, s3;
  wire [5:0] pins = {id_pin, line_se0, line_j, vbus_sess_vld,
    vbus_sess_end, vbus_vld};
  logic [5:0] pin_q;
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_sync
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          s1[g] <= 1'b0;
          s2[g] <= 1'b0;
          s3[g] <= 1'b0;
          pin_q[g] <= 1'b0;
        end else begin
          s1[g] <= pins[g];
          s2[g] <= s1[g];
          s3[g] <= s2[g];
          if (s2[g] == s3[g])
            pin_q[g] <= s3[g];
        end
      end
    end
  endgenerate
  wire plug_type_flag = pin_q[5];
  wire se0_live = pin_q[4];
  wire j_line_flag = pin_q[3];
  wire session_valid_flag = pin_q[2];
  wire session_end_flag = pin_q[1];
  wire vbus_valid_flag = pin_q[0];

  // line state stability timer
  uocs_line_t line_now, line_last;
  assign line_now = se0_live ? UOCS_LINE_SE0 :
    (j_line_flag ? UOCS_LINE_J : UOCS_LINE_K);
  logic [CW-1:0] stable_cnt;
  wire line_changed = (line_now != line_last);
  wire line_stable_flag = (stable_cnt == STABLE_MAX);
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      line_last <= UOCS_LINE_SE0;
      stable_cnt <= '0;
    end else begin
      line_last <= line_now;
      if (line_changed)
        stable_cnt <= '0;
      else if (!line_stable_flag)
        stable_cnt <= stable_cnt + 1'b1;
    end
  end

  // software registers
  uocs_byte_t otgcon, pwrc_sw, con_sw;
  logic activity_pending_flag;
  logic [3:0] last_endpoint_number;
  logic last_dir, pingpong_bank_indicator;

  // register index match, shared by every write enable
  function automatic logic reg_hit(input logic [`UOCS_ADDR_W-1:0] a,
    input logic [`UOCS_ADDR_W-1:0] ofs);
    reg_hit = (a == ofs);
  endfunction

  wire wr_otgcon = reg_wr && reg_hit(reg_addr, `UOCS_OFS_OTGCON);
  wire wr_pwrc = reg_wr && reg_hit(reg_addr, `UOCS_OFS_PWRC);
  wire wr_con = reg_wr && reg_hit(reg_addr, `UOCS_OFS_CON);
  wire [7:0] wbyte = reg_wdata[7:0];

  wire suspend_guard = pwrc_sw[`UOCS_BIT_GUARD];
  wire suspend_enable = pwrc_sw[`UOCS_BIT_SUSP];
  wire module_power_enable = pwrc_sw[`UOCS_BIT_PWR];
  wire packet_disable = con_sw[`UOCS_BIT_PACKET_DISABLE];
  wire host_mode_enable = con_sw[`UOCS_BIT_HOST_MODE_ENABLE];
  wire module_enable = con_sw[`UOCS_BIT_MODULE_ENABLE];
  wire otg_feature_enable = otgcon[`UOCS_BIT_OTG_FEATURE_ENABLE];

  // hardware clears suspend on detected resume; the event wins over a write
  wire [7:0] next_pwrc_w = wr_pwrc ? (wbyte & `UOCS_PWRC_WMASK) : pwrc_sw;
  wire [7:0] next_pwrc = resume_detect ?
    (next_pwrc_w & ~(8'h01 << `UOCS_BIT_SUSP)) : next_pwrc_w;
  wire [7:0] next_con_w = wr_con ? (wbyte & `UOCS_CON_WMASK) : con_sw;
  wire [7:0] next_con = setup_token ?
    (next_con_w | (8'h01 << `UOCS_BIT_PACKET_DISABLE)) : next_con_w;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      otgcon <= `UOCS_ZERO_BYTE;
      pwrc_sw <= `UOCS_ZERO_BYTE;
      con_sw <= `UOCS_ZERO_BYTE;
    end else begin
      if (wr_otgcon)
        otgcon <= wbyte & `UOCS_OTGCON_WMASK;
      pwrc_sw <= next_pwrc;
      con_sw <= next_con;
    end
  end

  // activity pending only asserted while the guard is set
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)
      activity_pending_flag <= 1'b0;
    else
      activity_pending_flag <= suspend_guard && activity_busy;
  end

  // last transfer status
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      last_endpoint_number <= 4'h0;
      last_dir <= 1'b0;
      pingpong_bank_indicator <= 1'b0;
    end else if (xfer_done) begin
      last_endpoint_number <= xfer_endpoint;
      last_dir <= xfer_tx;
      pingpong_bank_indicator <= xfer_odd;
    end
  end

  // pull resistor and VBUS control
  wire hw_dp_pu = module_enable && !host_mode_enable;
  wire hw_pd = host_mode_enable;
  wire [7:0] con_read = {1'b0, se0_live, packet_disable, 1'b0,
    host_mode_enable, con_sw[`UOCS_BIT_RESUME],
    con_sw[`UOCS_BIT_PINGPONG_RESET], module_enable};

  // software pull bits only count with OTG on; otherwise the mode bits rule and the D- pull-up stays off
  wire next_dplus_pullup = otg_feature_enable ?
    otgcon[`UOCS_BIT_DPPU] : hw_dp_pu;
  wire next_dminus_pullup = otg_feature_enable &&
    otgcon[`UOCS_BIT_DMPU];
  wire next_dplus_pulldown = otg_feature_enable ?
    otgcon[`UOCS_BIT_DPPD] : hw_pd;
  wire next_dminus_pulldown = otg_feature_enable ?
    otgcon[`UOCS_BIT_DMPD] : hw_pd;
  wire next_module_active = module_power_enable && module_enable &&
    !suspend_enable;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dplus_pullup <= 1'b0;
      dminus_pullup <= 1'b0;
      dplus_pulldown <= 1'b0;
      dminus_pulldown <= 1'b0;
    end else begin
      dplus_pullup <= next_dplus_pullup;
      dminus_pullup <= next_dminus_pullup;
      dplus_pulldown <= next_dplus_pulldown;
      dminus_pulldown <= next_dminus_pulldown;
    end
  end

  // VBUS drive follows the software bits with no mode gating
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      vbus_power_on <= 1'b0;
      vbus_charge_select <= 1'b0;
      vbus_discharge_enable <= 1'b0;
    end else begin
      vbus_power_on <= otgcon[`UOCS_BIT_VBON];
      vbus_charge_select <= otgcon[`UOCS_BIT_VBCHG];
      vbus_discharge_enable <= otgcon[`UOCS_BIT_VBDIS];
    end
  end

  // suspend stops the clock and parks the transceiver together
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      usb_clk_gate_n <= 1'b1;
      xcvr_low_power <= 1'b0;
      module_active <= 1'b0;
    end else begin
      usb_clk_gate_n <= !suspend_enable;
      xcvr_low_power <= suspend_enable;
      module_active <= next_module_active;
    end
  end

  // engine control levels for the transfer logic
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      engine_halt <= 1'b0;
      resume_drive <= 1'b0;
      pingpong_force_even <= 1'b0;
    end else begin
      engine_halt <= packet_disable;
      resume_drive <= con_sw[`UOCS_BIT_RESUME];
      pingpong_force_even <= con_sw[`UOCS_BIT_PINGPONG_RESET];
    end
  end

  // read path: upper byte always zero
  wire [7:0] stat_read = {plug_type_flag, 1'b0, line_stable_flag, 1'b0,
    session_valid_flag, session_end_flag, 1'b0, vbus_valid_flag};
  wire [7:0] pwrc_read = {activity_pending_flag, 2'b00, suspend_guard,
    2'b00, suspend_enable, module_power_enable};
  wire [7:0] last_read = {last_endpoint_number, last_dir,
    pingpong_bank_indicator, 2'b00};
  logic [7:0] rd_sel;
  always_comb begin
    unique case (reg_addr)
      `UOCS_OFS_OTGSTAT: rd_sel = stat_read;
      `UOCS_OFS_OTGCON: rd_sel = otgcon;
      `UOCS_OFS_PWRC: rd_sel = pwrc_read;
      `UOCS_OFS_STAT: rd_sel = last_read;
      `UOCS_OFS_CON: rd_sel = con_read;
      default: rd_sel = `UOCS_ZERO_BYTE;
    endcase
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
      reg_rdata <= {`UOCS_ZERO_BYTE, rd_sel};
    else
      reg_rdata <= 16'h0000;
  end
endmodule

// [test/uocs_regs_props.sv]
`timescale 1ns/1ps
`include "uocs_params.svh"
module uocs_props
  import uocs_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [`UOCS_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic xfer_done,
  input wire logic [3:0] xfer_endpoint,
  input wire logic xfer_tx,
  input wire logic xfer_odd,
  input wire logic setup_token,
  input wire logic resume_detect,
  input wire logic usb_clk_gate_n,
  input wire logic xcvr_low_power,
  input wire logic engine_halt,
  input wire logic resume_drive,
  input wire logic pingpong_force_even
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_con_wr;
    reg_wr && reg_addr == `UOCS_OFS_CON;
  endsequence
  sequence s_stat_rd;
    xfer_done ##1 (reg_rd && reg_addr == `UOCS_OFS_STAT && !xfer_done);
  endsequence
  property p_con_pin(int b, logic pin);
    s_con_wr |-> ##2 pin == $past(reg_wdata[b], 2);
  endproperty
  a_upper_byte_zero: assert property (reg_rdata[15:8] == 8'h00)
    else $error("upper byte of read data not zero");
  a_rdata_idle_zero: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside read answer");
  a_suspend_pair: assert property (
    usb_clk_gate_n != xcvr_low_power)
    else $error("clock gate and low power disagree");
  a_wake_on_resume: assert property (
    resume_detect |-> ##[1:2] usb_clk_gate_n)
    else $error("suspend not cleared by resume");
  a_setup_halts: assert property (
    setup_token |-> ##[1:2] engine_halt)
    else $error("setup token did not halt engine");
  a_resume_drive: assert property (
    p_con_pin(`UOCS_BIT_RESUME, resume_drive))
    else $error("resume drive does not follow control bit");
  a_force_even: assert property (
    p_con_pin(`UOCS_BIT_PINGPONG_RESET, pingpong_force_even))
    else $error("force even does not follow control bit");
  a_stat_capture: assert property (
    s_stat_rd |=> reg_rdata[7:2] ==
    {$past(xfer_endpoint, 2), $past(xfer_tx, 2), $past(xfer_odd, 2)})
    else $error("transfer status not captured");
endmodule
bind uocs_regs uocs_props u_props (.core_clk(core_clk), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xfer_done(xfer_done),
  .xfer_endpoint(xfer_endpoint), .xfer_tx(xfer_tx), .xfer_odd(xfer_odd),
  .setup_token(setup_token), .resume_detect(resume_detect),
  .usb_clk_gate_n(usb_clk_gate_n), .xcvr_low_power(xcvr_low_power),
  .engine_halt(engine_halt), .resume_drive(resume_drive),
  .pingpong_force_even(pingpong_force_even));

// [test/uocs_regs_tb_top.sv]
`timescale 1ns/1ps
module uocs_regs_tb_top import uocs_pkg::*;;
  logic core_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0;
  logic activity_busy = 1;
  logic [2:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0;
  logic [15:0] reg_rdata;
  logic [3:0] xfer_endpoint;
  wire [3:0] pulls;
  logic id_pin, line_se0, line_j, vbus_sess_vld, vbus_sess_end, vbus_vld;
  logic xfer_done, xfer_tx, xfer_odd, setup_token, resume_detect;
  logic cg, eh, rsd, ppf, lp, ma, vbon, vchg, vdis;
  int n_mismatch = 0, tests_run = 0, cyc = 0;
  uocs_usb_far u_far (.core_clk(core_clk), .id_pin(id_pin),
    .line_se0(line_se0), .line_j(line_j), .vbus_sess_vld(vbus_sess_vld),
    .vbus_sess_end(vbus_sess_end), .vbus_vld(vbus_vld),
    .xfer_done(xfer_done), .xfer_endpoint(xfer_endpoint), .xfer_tx(xfer_tx),
    .xfer_odd(xfer_odd), .setup_token(setup_token),
    .resume_detect(resume_detect));
  uocs_regs #(.STABLE_CYCLES(20)) u_dut (.core_clk(core_clk),
    .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .id_pin(id_pin), .line_se0(line_se0), .line_j(line_j),
    .vbus_sess_vld(vbus_sess_vld), .vbus_sess_end(vbus_sess_end),
    .vbus_vld(vbus_vld), .xfer_done(xfer_done),
    .xfer_endpoint(xfer_endpoint), .xfer_tx(xfer_tx), .xfer_odd(xfer_odd),
    .setup_token(setup_token), .activity_busy(activity_busy),
    .resume_detect(resume_detect), .dplus_pullup(pulls[3]),
    .dminus_pullup(pulls[2]), .dplus_pulldown(pulls[1]),
    .dminus_pulldown(pulls[0]), .vbus_power_on(vbon),
    .vbus_charge_select(vchg), .vbus_discharge_enable(vdis),
    .usb_clk_gate_n(cg), .xcvr_low_power(lp),
    .module_active(ma), .engine_halt(eh), .resume_drive(rsd),
    .pingpong_force_even(ppf));
  initial forever #5 core_clk = ~core_clk;
  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge core_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge core_clk);
    reg_wr <= 0;
  endtask
  task rd(input logic [2:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge core_clk);
    reg_rd <= 0;
    @(negedge core_clk);
    chk("reg_rdata", exp, reg_rdata);
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      give_verdict;
    end
  end
  initial begin
    repeat (12) @(posedge core_clk);
    reset_n <= 1;
    repeat (30) @(posedge core_clk);
    rd(0, 16'h00A4);
    for (int a = 1; a < 5; a++) rd(a[2:0], 16'h0000);
    u_far.bus(6'b001101);
    repeat (6) @(posedge core_clk);
    rd(0, 16'h0029);
    u_far.bus(6'b010101);
    repeat (6) @(posedge core_clk);
    rd(0, 16'h0009);
    repeat (20) @(posedge core_clk);
    rd(0, 16'h0029);
    $display("test status done");
    wr(4, 16'hFF2F);
    rd(4, 16'h006F);
    chk("con pins", 16'h0007, {13'h0, eh, rsd, ppf});
    wr(4, 16'h0000);
    u_far.ev(1, 0);
    rd(4, 16'h0060);
    wr(4, 16'h0001);
    repeat (2) @(negedge core_clk);
    chk("pulls", 16'h0008, {12'h0, pulls});
    wr(4, 16'h0009);
    repeat (2) @(negedge core_clk);
    chk("pulls", 16'h0003, {12'h0, pulls});
    wr(1, 16'h00C4);
    repeat (2) @(negedge core_clk);
    chk("pulls", 16'h000C, {12'h0, pulls});
    wr(1, 16'hFF34);
    rd(1, 16'h0034);
    chk("pulls", 16'h0003, {12'h0, pulls});
    wr(1, 16'h000B);
    repeat (2) @(negedge core_clk);
    chk("vbus", 16'h0007, {13'h0, vbon, vchg, vdis});
    $display("test control done");
    wr(2, 16'h0011);
    wr(2, 16'h0013);
    repeat (2) @(negedge core_clk);
    chk("suspend pins", 16'h0001, {14'h0, cg, lp});
    rd(2, 16'h0093);
    u_far.ev(0, 1);
    rd(2, 16'h0091);
    chk("wake pins", 16'h0003, {14'h0, cg, ma});
    @(posedge core_clk);
    activity_busy <= 0;
    rd(2, 16'h0011);
    u_far.xfer(4'hF, 1, 1);
    rd(3, 16'h00FC);
    u_far.xfer(4'h0, 0, 0);
    rd(3, 16'h0000);
    wr(7, 16'h00FF);
    rd(7, 16'h0000);
    wr(1, 16'h0000);
    wr(4, 16'h0000);
    wr(2, 16'h0000);
    rd(2, 16'h0000);
    $display("test power done");
    wr(4, 16'h0005);
    @(posedge core_clk);
    reset_n <= 0;
    repeat (3) @(posedge core_clk);
    reset_n <= 1;
    @(negedge core_clk);
    chk("reset pins", 16'h0020, {10'h0, cg, rsd, pulls});
    repeat (6) @(posedge core_clk);
    rd(4, 16'h0040);
    $display("test reset done");
    give_verdict;
  end
endmodule

// [test/uocs_usb_far.sv]
`timescale 1ns/1ps
module uocs_usb_far (
  input wire logic core_clk,
  output logic id_pin,
  output logic line_se0,
  output logic line_j,
  output logic vbus_sess_vld,
  output logic vbus_sess_end,
  output logic vbus_vld,
  output logic xfer_done,
  output logic [3:0] xfer_endpoint,
  output logic xfer_tx,
  output logic xfer_odd,
  output logic setup_token,
  output logic resume_detect
);
  initial begin
    {id_pin, line_se0, line_j, vbus_sess_vld, vbus_sess_end} = 5'b10101;
    {vbus_vld, xfer_done, xfer_endpoint, xfer_tx, xfer_odd} = 8'h00;
    {setup_token, resume_detect} = 2'b00;
  end
  // event pulses last one cycle; the raising task forks this off
  task end_pulse;
    @(posedge core_clk);
    {xfer_done, setup_token, resume_detect} <= 3'b000;
  endtask
  task bus(input logic [5:0] v);
    @(posedge core_clk);
    {id_pin, line_se0, line_j, vbus_sess_vld, vbus_sess_end, vbus_vld} <= v;
  endtask
  task xfer(input logic [3:0] ep, input logic tx, input logic odd);
    @(posedge core_clk);
    {xfer_done, xfer_endpoint, xfer_tx, xfer_odd} <= {1'b1, ep, tx, odd};
    fork
      end_pulse;
    join_none
  endtask
  task ev(input logic s, input logic r);
    @(posedge core_clk);
    {setup_token, resume_detect} <= {s, r};
    fork
      end_pulse;
    join_none
  endtask
endmodule
